// >>> verilog/ccv_cfg.svh
// Constants of the character video control block: register indexes,
// field positions and reset values. Included by the package and modules.
`ifndef CCV_CFG_SVH
`define CCV_CFG_SVH
// ==========================================================
// Register indexes (byte address is four times the index)
`define CCV_IDX_BASE 16'h1000
`define CCV_IDX_HORIZ 16'h1000
`define CCV_IDX_VERT 16'h1001
`define CCV_IDX_COLS 16'h1002
`define CCV_IDX_ROWS 16'h1003
`define CCV_IDX_RASTER 16'h1004
`define CCV_IDX_BASEADDR 16'h1005
`define CCV_IDX_PEN_H 16'h1006
`define CCV_IDX_PEN_V 16'h1007
`define CCV_IDX_PAD_X 16'h1008
`define CCV_IDX_PAD_Y 16'h1009
`define CCV_IDX_AMP12 16'h100a
`define CCV_IDX_SAW 16'h100b
`define CCV_IDX_PULSE 16'h100c
`define CCV_IDX_SQNOISE 16'h100d
`define CCV_IDX_AMP3AUX 16'h100e
`define CCV_IDX_COLOUR 16'h100f
// ==========================================================
// Field positions
`define CCV_WEAVE_BIT 7
`define CCV_SWAP_BIT 7
`define CCV_TALL_BIT 0
`define CCV_HISS_BIT 0
`define CCV_RASTER_LSB_BIT 7
// ==========================================================
// Reset values and bus answers
`define CCV_RST_REG 8'h00
`define CCV_RST_LINE 9'h000
`define CCV_RESP_OKAY 1'b0
`endif

// >>> verilog/ccv_pkg.sv
// Types shared by the character video control block.
// Assumes ccv_cfg.svh is on the include path.
`include "ccv_cfg.svh"
`default_nettype none
package ccv_pkg;
  typedef logic [7:0] ccv_byte_t;
  typedef logic [3:0] ccv_colour_t;
  typedef enum logic {CCV_IDLE, CCV_WDATA} ccv_phase_e;
  typedef struct packed {
    ccv_phase_e phase;
    logic [3:0] widx;
    logic [15:0][7:0] regs;
    logic [8:0] raster;
    ccv_byte_t pen_h;
    ccv_byte_t pen_v;
    ccv_byte_t pad_x;
    ccv_byte_t pad_y;
    logic [31:0] rdata;
    logic ready;
    ccv_colour_t colour;
  } ccv_top_s;
endpackage
`default_nettype wire

// >>> verilog/ccv_pixel.sv
// Per-dot colour selection for one character cell.
// Assumes cell data, colour pointer and dot position are stable this cycle.
`include "ccv_cfg.svh"
`default_nettype none
module ccv_pixel (
  input wire logic [7:0] cell_bits, // Cell byte of this line
  input wire ccv_pkg::ccv_colour_t colour_ptr, // Cell colour pointer
  input wire logic [2:0] dot_pos, // Dot within cell, 0 leftmost
  input wire logic in_matrix, // Dot lies inside the matrix
  input wire logic hue_swap, // Own colours on common background
  input wire ccv_pkg::ccv_colour_t background, // Common background
  input wire ccv_pkg::ccv_colour_t border, // Exterior border
  input wire ccv_pkg::ccv_colour_t aux, // Auxiliary colour
  output ccv_pkg::ccv_colour_t dot_colour // Selected colour
);
  import ccv_pkg::*;
  logic fine_bit;
  logic [1:0] pair;
  ccv_colour_t fg;
  always_comb
  begin
    fg = {1'b0, colour_ptr[2:0]};
    fine_bit = cell_bits[~dot_pos];
    case (dot_pos[2:1])
      2'd0: pair = cell_bits[7:6];
      2'd1: pair = cell_bits[5:4];
      2'd2: pair = cell_bits[3:2];
      default: pair = cell_bits[1:0];
    endcase
    if (!in_matrix)
      dot_colour = border;
    else if (colour_ptr[3])
    begin
      case (pair)
        2'b00: dot_colour = background;
        2'b01: dot_colour = border;
        2'b10: dot_colour = fg;
        default: dot_colour = aux;
      endcase
    end
    else if (!hue_swap)
      dot_colour = fine_bit ? background : fg;
    else
      dot_colour = fine_bit ? fg : background;
  end
endmodule
`default_nettype wire

// >>> verilog/ccv_top.sv
// Control registers and dot colour stage of the character video block.
// Assumes an AHB-Lite master with single word transfers, and a timing
// generator that supplies scan line, beam position and cell data.
//
// The AHB-Lite register port and the register offsets were decided locally.
`include "ccv_cfg.svh"
`default_nettype none
module ccv_top (
  input wire logic hclk, // Bus clock, 10 MHz
  input wire logic hresetn, // Asynchronous reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size, word only
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  input wire logic [8:0] scan_line, // Line now being scanned
  input wire ccv_pkg::ccv_byte_t beam_h, // Beam horizontal position
  input wire logic pen_strobe, // Light pen hit pulse
  input wire ccv_pkg::ccv_byte_t paddle_x_in, // Digitised paddle X
  input wire ccv_pkg::ccv_byte_t paddle_y_in, // Digitised paddle Y
  input wire logic paddle_load, // Paddle conversion done pulse
  input wire logic [7:0] cell_bits, // Cell byte for this dot
  input wire ccv_pkg::ccv_colour_t colour_ptr, // Cell colour pointer
  input wire logic [2:0] dot_pos, // Dot within cell
  input wire logic in_matrix, // Dot inside the matrix
  output logic [31:0] hrdata, // Read data
  output logic hreadyout, // Slave ready
  output logic hresp, // Response, always OKAY
  output logic [6:0] h_origin, // First column offset
  output logic interlace, // Interlaced scan
  output ccv_pkg::ccv_byte_t v_origin, // First row offset
  output logic [6:0] matrix_cols, // Matrix columns
  output logic hue_swap, // Own colours on background
  output logic [5:0] matrix_rows, // Matrix rows
  output logic tall_cells, // Tall cells, 8 dots wide
  output logic [2:0] char_base, // Cell memory A13..A11
  output logic [3:0] matrix_base, // Matrix memory A13..A10
  output logic hiss_sel, // Oscillator 3 noise
  output ccv_pkg::ccv_colour_t amp_one, // Oscillator 1 amplitude
  output ccv_pkg::ccv_colour_t amp_two, // Oscillator 2 amplitude
  output ccv_pkg::ccv_colour_t amp_three, // Oscillator 3 amplitude
  output ccv_pkg::ccv_byte_t saw_freq, // Oscillator 1 frequency
  output ccv_pkg::ccv_byte_t pulse_freq, // Oscillator 2 frequency
  output ccv_pkg::ccv_byte_t sq_noise_freq, // Oscillator 3 frequency
  output ccv_pkg::ccv_colour_t aux_colour, // Auxiliary colour
  output ccv_pkg::ccv_colour_t background_colour, // Common background
  output ccv_pkg::ccv_colour_t border_colour, // Border colour
  output ccv_pkg::ccv_colour_t dot_colour // Registered dot colour
);
  import ccv_pkg::*;

  // ==========================================================
  // Address decode
  function automatic logic [4:0] reg_decode(input logic [31:0] addr);
    reg_decode = {addr[31:6] == 26'(`CCV_IDX_BASE >> 4), addr[5:2]};
  endfunction

  function automatic logic writable(input logic [3:0] idx);
    writable = !(idx == 4'(`CCV_IDX_RASTER) || idx == 4'(`CCV_IDX_PEN_H)
      || idx == 4'(`CCV_IDX_PEN_V) || idx == 4'(`CCV_IDX_PAD_X)
      || idx == 4'(`CCV_IDX_PAD_Y));
  endfunction

  ccv_top_s st_ff;
  ccv_top_s nxt_st;
  logic [4:0] adec;
  logic take;
  ccv_colour_t pix_colour;
  logic [7:0] rbyte;

  assign adec = reg_decode(haddr);
  assign take = hsel && htrans[1] && hready;

  // ==========================================================
  // Dot colour
  ccv_pixel ccv_pixel_i (
    .cell_bits(cell_bits),
    .colour_ptr(colour_ptr),
    .dot_pos(dot_pos),
    .in_matrix(in_matrix),
    .hue_swap(hue_swap),
    .background(background_colour),
    .border(border_colour),
    .aux(aux_colour),
    .dot_colour(pix_colour)
  );

  // ==========================================================
  // Next state
  always_comb
  begin
    nxt_st = st_ff;
    rbyte = 8'h00;
    nxt_st.ready = 1'b1;
    nxt_st.colour = pix_colour;
    nxt_st.raster = scan_line;
    if (pen_strobe)
    begin
      nxt_st.pen_h = beam_h;
      nxt_st.pen_v = scan_line[8:1];
    end
    if (paddle_load)
    begin
      nxt_st.pad_x = paddle_x_in;
      nxt_st.pad_y = paddle_y_in;
    end
    // Data phase of an accepted write
    if (st_ff.phase == CCV_WDATA)
    begin
      if (writable(st_ff.widx))
        nxt_st.regs[st_ff.widx] = hwdata[7:0];
      if (st_ff.widx == 4'(`CCV_IDX_ROWS))
        nxt_st.regs[st_ff.widx][`CCV_RASTER_LSB_BIT] = 1'b0;
    end
    nxt_st.phase = CCV_IDLE;
    if (take && hwrite && adec[4])
    begin
      nxt_st.phase = CCV_WDATA;
      nxt_st.widx = adec[3:0];
    end
    // Read data taken from the updated registers
    if (take && !hwrite && adec[4])
    begin
      case (adec[3:0])
        4'(`CCV_IDX_RASTER): rbyte = nxt_st.raster[8:1];
        4'(`CCV_IDX_ROWS): rbyte = {nxt_st.raster[0],
          nxt_st.regs[adec[3:0]][6:0]};
        4'(`CCV_IDX_PEN_H): rbyte = nxt_st.pen_h;
        4'(`CCV_IDX_PEN_V): rbyte = nxt_st.pen_v;
        4'(`CCV_IDX_PAD_X): rbyte = nxt_st.pad_x;
        4'(`CCV_IDX_PAD_Y): rbyte = nxt_st.pad_y;
        default: rbyte = nxt_st.regs[adec[3:0]];
      endcase
    end
    if (take && !hwrite)
      nxt_st.rdata = {24'h000000, rbyte};
  end

  // ==========================================================
  // State register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_ff.phase <= CCV_IDLE;
      st_ff.widx <= 4'h0;
      st_ff.regs <= {16{`CCV_RST_REG}};
      st_ff.raster <= `CCV_RST_LINE;
      st_ff.pen_h <= `CCV_RST_REG;
      st_ff.pen_v <= `CCV_RST_REG;
      st_ff.pad_x <= `CCV_RST_REG;
      st_ff.pad_y <= `CCV_RST_REG;
      st_ff.rdata <= 32'h00000000;
      st_ff.ready <= 1'b1;
      st_ff.colour <= 4'h0;
    end
    else
      st_ff <= nxt_st;
  end

  // ==========================================================
  // Outputs
  assign hrdata = st_ff.rdata;
  assign hreadyout = st_ff.ready;
  assign hresp = `CCV_RESP_OKAY;
  assign dot_colour = st_ff.colour;
  assign h_origin = st_ff.regs[4'(`CCV_IDX_HORIZ)][6:0];
  assign interlace = st_ff.regs[4'(`CCV_IDX_HORIZ)][`CCV_WEAVE_BIT];
  assign v_origin = st_ff.regs[4'(`CCV_IDX_VERT)];
  assign matrix_cols = st_ff.regs[4'(`CCV_IDX_COLS)][6:0];
  assign hue_swap = st_ff.regs[4'(`CCV_IDX_COLS)][`CCV_SWAP_BIT];
  assign matrix_rows = st_ff.regs[4'(`CCV_IDX_ROWS)][6:1];
  assign tall_cells = st_ff.regs[4'(`CCV_IDX_ROWS)][`CCV_TALL_BIT];
  assign char_base = st_ff.regs[4'(`CCV_IDX_BASEADDR)][3:1];
  assign matrix_base = st_ff.regs[4'(`CCV_IDX_BASEADDR)][7:4];
  assign hiss_sel = st_ff.regs[4'(`CCV_IDX_BASEADDR)][`CCV_HISS_BIT];
  assign amp_one = st_ff.regs[4'(`CCV_IDX_AMP12)][3:0];
  assign amp_two = st_ff.regs[4'(`CCV_IDX_AMP12)][7:4];
  assign saw_freq = st_ff.regs[4'(`CCV_IDX_SAW)];
  assign pulse_freq = st_ff.regs[4'(`CCV_IDX_PULSE)];
  assign sq_noise_freq = st_ff.regs[4'(`CCV_IDX_SQNOISE)];
  assign amp_three = st_ff.regs[4'(`CCV_IDX_AMP3AUX)][3:0];
  assign aux_colour = st_ff.regs[4'(`CCV_IDX_AMP3AUX)][7:4];
  assign background_colour = st_ff.regs[4'(`CCV_IDX_COLOUR)][7:4];
  assign border_colour = st_ff.regs[4'(`CCV_IDX_COLOUR)][3:0];

  // ==========================================================
  // Checks
  logic wr_now;
  assign wr_now = st_ff.phase == CCV_WDATA;

  property p_origin_wr;
    @(posedge hclk) disable iff (!hresetn)
    (wr_now && st_ff.widx == 4'(`CCV_IDX_HORIZ))
      |=> h_origin == $past(hwdata[6:0]) && interlace == $past(hwdata[7]);
  endproperty
  a_origin_wr: assert property (p_origin_wr)
    else $error("horizontal origin write not applied");

  property p_rows_wr;
    @(posedge hclk) disable iff (!hresetn)
    (wr_now && st_ff.widx == 4'(`CCV_IDX_ROWS))
      |=> matrix_rows == $past(hwdata[6:1]) && tall_cells == $past(hwdata[0]);
  endproperty
  a_rows_wr: assert property (p_rows_wr)
    else $error("row count write not applied");

  property p_base_wr;
    @(posedge hclk) disable iff (!hresetn)
    (wr_now && st_ff.widx == 4'(`CCV_IDX_BASEADDR))
      |=> {matrix_base, char_base, hiss_sel} == $past(hwdata[7:0]);
  endproperty
  a_base_wr: assert property (p_base_wr)
    else $error("base address write not applied");

  property p_raster_rd;
    @(posedge hclk) disable iff (!hresetn)
    (take && !hwrite && haddr[31:2] == 30'(`CCV_IDX_RASTER))
      |=> hrdata == {24'h000000, $past(scan_line[8:1])};
  endproperty
  a_raster_rd: assert property (p_raster_rd)
    else $error("raster read wrong");

  property p_rowbit_rd;
    @(posedge hclk) disable iff (!hresetn)
    (take && !hwrite && haddr[31:2] == 30'(`CCV_IDX_ROWS))
      |=> hrdata[7] == $past(scan_line[0]);
  endproperty
  a_rowbit_rd: assert property (p_rowbit_rd)
    else $error("raster low bit missing from row count");

  property p_pen;
    @(posedge hclk) disable iff (!hresetn)
    pen_strobe ##1 (!pen_strobe)[*2]
      |-> st_ff.pen_h == $past(beam_h, 2) && st_ff.pen_v == $past(scan_line[8:1], 2);
  endproperty
  a_pen: assert property (p_pen)
    else $error("pen position not held");

  property p_paddle;
    @(posedge hclk) disable iff (!hresetn)
    paddle_load |=> st_ff.pad_x == $past(paddle_x_in) && st_ff.pad_y == $past(paddle_y_in);
  endproperty
  a_paddle: assert property (p_paddle)
    else $error("paddle values not loaded");

  property p_ro_ignored;
    @(posedge hclk) disable iff (!hresetn)
    (wr_now && !writable(st_ff.widx)) |=> $stable(st_ff.regs);
  endproperty
  a_ro_ignored: assert property (p_ro_ignored)
    else $error("write to report-only register changed state");

  property p_sound_wr;
    @(posedge hclk) disable iff (!hresetn)
    (wr_now && st_ff.widx == 4'(`CCV_IDX_AMP3AUX))
      |=> {aux_colour, amp_three} == $past(hwdata[7:0]);
  endproperty
  a_sound_wr: assert property (p_sound_wr)
    else $error("amplitude three write not applied");

  property p_mc_border;
    @(posedge hclk) disable iff (!hresetn)
    (in_matrix && colour_ptr[3] && dot_pos[2:1] == 2'd0 && cell_bits[7:6] == 2'b01)
      |=> dot_colour == $past(border_colour);
  endproperty
  a_mc_border: assert property (p_mc_border)
    else $error("paired code 01 not border");

  property p_fine_fg;
    @(posedge hclk) disable iff (!hresetn)
    (in_matrix && !colour_ptr[3] && hue_swap && cell_bits[~dot_pos])
      |=> dot_colour == {1'b0, $past(colour_ptr[2:0])};
  endproperty
  a_fine_fg: assert property (p_fine_fg)
    else $error("fine dot one not foreground");

  property p_swap_inv;
    @(posedge hclk) disable iff (!hresetn)
    (in_matrix && !colour_ptr[3] && !hue_swap && cell_bits[~dot_pos])
      |=> dot_colour == $past(background_colour);
  endproperty
  a_swap_inv: assert property (p_swap_inv)
    else $error("inverted cell one not background");

  property p_outside;
    @(posedge hclk) disable iff (!hresetn)
    !in_matrix |=> dot_colour == $past(border_colour);
  endproperty
  a_outside: assert property (p_outside)
    else $error("dot outside matrix not border");

  property p_mc_swap;
    @(posedge hclk) disable iff (!hresetn)
    (in_matrix && colour_ptr[3] && !hue_swap && dot_pos[2:1] == 2'd1
      && cell_bits[5:4] == 2'b10)
      |=> dot_colour == {1'b0, $past(colour_ptr[2:0])};
  endproperty
  a_mc_swap: assert property (p_mc_swap)
    else $error("paired code 10 not foreground");

  property p_ready;
    @(posedge hclk) disable iff (!hresetn)
    take |=> hreadyout && hresp == 1'b0;
  endproperty
  a_ready: assert property (p_ready)
    else $error("slave not ready with OKAY");
endmodule
`default_nettype wire

// >>> testbench/ccv_host_model.sv
// Host bus master model for the character video control block.
// Assumes one AHB-Lite slave whose hreadyout is fed back as hready.
`default_nettype none
module ccv_host_model (
  input wire logic hclk, // Bus clock
  input wire logic hresetn, // Reset, active low
  input wire logic go, // One-cycle request for a transfer
  input wire logic go_write, // Requested transfer is a write
  input wire logic [31:0] go_addr, // Requested byte address
  input wire logic [31:0] go_wdata, // Requested write data
  input wire logic hready, // Bus ready
  input wire logic [31:0] hrdata, // Read data
  output logic hsel, // Slave select
  output logic [31:0] haddr, // Byte address
  output logic [1:0] htrans, // Transfer type
  output logic hwrite, // Write when high
  output logic [2:0] hsize, // Always a word
  output logic [31:0] hwdata, // Write data
  output logic done, // One cycle at end of data phase
  output logic [31:0] got_rdata // Read data taken at that edge
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] st;
  // ==========================================================
  // Single transfers; released address and write data lines show inverted old values
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st <= 2'd0;
      hsel <= 1'b0;
      htrans <= 2'b00;
      haddr <= 32'h0;
      hwrite <= 1'b0;
      hsize <= 3'h2;
      hwdata <= 32'h0;
      done <= 1'b0;
      got_rdata <= 32'h0;
    end
    else
    begin
      done <= 1'b0;
      if (st == 2'd0 && go)
      begin
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= go_addr;
        hwrite <= go_write;
        st <= 2'd1;
      end
      else if (st == 2'd1 && hready)
      begin
        hsel <= 1'b0;
        htrans <= 2'b00;
        haddr <= ~haddr;
        hwdata <= go_wdata;
        st <= 2'd2;
      end
      else if (st == 2'd2 && hready)
      begin
        got_rdata <= hrdata;
        hwdata <= ~hwdata;
        done <= 1'b1;
        st <= 2'd0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> testbench/ccv_top_bench.sv
// Self-checking bench of the character video control block.
// Assumes the design files and the host model are compiled first.
`include "ccv_cfg.svh"
`default_nettype none
module ccv_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 1'b0, hresetn = 1'b0, go = 1'b0, go_write = 1'b0;
  logic pen_strobe = 1'b0, paddle_load = 1'b0, in_matrix = 1'b0;
  logic [31:0] go_addr = 32'h0, go_wdata = 32'h0;
  logic [8:0] scan_line = 9'h0a5;
  logic [7:0] beam_h = 8'h00, paddle_x_in = 8'h00, paddle_y_in = 8'h00, cell_bits = 8'h00;
  logic [3:0] colour_ptr = 4'h0;
  logic [2:0] dot_pos = 3'h0;
  logic hsel, hwrite, hready, hreadyout, hresp, done, interlace, hue_swap, tall_cells, hiss_sel;
  logic [31:0] haddr, hwdata, hrdata, got_rdata, rd, ex;
  logic [1:0] htrans;
  logic [2:0] hsize, char_base;
  logic [6:0] h_origin, matrix_cols;
  logic [5:0] matrix_rows;
  logic [3:0] matrix_base, amp_one, amp_two, amp_three, aux_colour;
  logic [3:0] background_colour, border_colour, dot_colour;
  logic [7:0] v_origin, saw_freq, pulse_freq, sq_noise_freq, r, r2;
  logic [7:0] sh [16] = '{default: 8'h00};
  logic [15:0] seed = 16'd13086;
  int bad_count = 0, n_compared = 0, i, k, n;
  assign hready = hreadyout;
  always #50 hclk = ~hclk;
  ccv_host_model ccv_host_model_i (.hclk, .hresetn, .go, .go_write, .go_addr, .go_wdata,
    .hready, .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .done, .got_rdata);
  ccv_top ccv_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .scan_line, .beam_h, .pen_strobe, .paddle_x_in, .paddle_y_in, .paddle_load,
    .cell_bits, .colour_ptr, .dot_pos, .in_matrix, .hrdata, .hreadyout, .hresp, .h_origin,
    .interlace, .v_origin, .matrix_cols, .hue_swap, .matrix_rows, .tall_cells, .char_base,
    .matrix_base, .hiss_sel, .amp_one, .amp_two, .amp_three, .saw_freq, .pulse_freq,
    .sq_noise_freq, .aux_colour, .background_colour, .border_colour, .dot_colour);
  // ==========================================================
  // Helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {1'b0, s[15:1]} ^ (s[0] ? 16'hb400 : 16'h0000);
  endfunction
  task automatic rnd();
    seed = lfsr(seed);
    r = seed[7:0];
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus_op(input logic wr, input int idx, input logic [7:0] wv);
    @(posedge hclk);
    go <= 1'b1;
    go_write <= wr;
    go_addr <= (32'(`CCV_IDX_BASE) + 32'(idx)) << 2;
    go_wdata <= {24'h0, wv};
    @(posedge hclk);
    go <= 1'b0;
    while (done !== 1'b1)
    begin
      @(posedge hclk);
      #1;
    end
    rd = got_rdata;
  endtask
  function automatic logic [31:0] exp_rd(input int idx);
    logic [7:0] v;
    v = (idx < 16) ? sh[idx] : 8'h00;
    if (idx == 3)
      v[7] = scan_line[0];
    if (idx == 4)
      v = scan_line[8:1];
    exp_rd = {24'h0, v};
  endfunction
  function automatic logic [7:0] obs(input int idx);
    case (idx)
      0: obs = {interlace, h_origin};
      1: obs = v_origin;
      2: obs = {hue_swap, matrix_cols};
      3: obs = {1'b0, matrix_rows, tall_cells};
      5: obs = {matrix_base, char_base, hiss_sel};
      10: obs = {amp_two, amp_one};
      11: obs = saw_freq;
      12: obs = pulse_freq;
      13: obs = sq_noise_freq;
      14: obs = {aux_colour, amp_three};
      default: obs = {background_colour, border_colour};
    endcase
  endfunction
  function automatic logic [3:0] dot_exp(input logic [7:0] c, input logic [3:0] p,
    input logic [2:0] d, input logic m);
    logic [1:0] code;
    code = 2'(c >> (3'd6 - {d[2:1], 1'b0}));
    if (!m)
      dot_exp = sh[15][3:0];
    else if (p[3])
      dot_exp = (code == 2'b00) ? sh[15][7:4] : (code == 2'b01) ? sh[15][3:0] :
        (code == 2'b10) ? {1'b0, p[2:0]} : sh[14][7:4];
    else
      dot_exp = (c[3'd7 - d] == sh[2][7]) ? {1'b0, p[2:0]} : sh[15][7:4];
  endfunction
  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    check("hreadyout", {31'h0, hreadyout}, 32'h1);
    check("hresp", {31'h0, hresp}, 32'h0);
    for (i = 0; i < 16; i++)
    begin
      bus_op(1'b0, i, 8'h00);
      check("reset read", rd, exp_rd(i));
    end
    for (k = 0; k < 3; k++)
    begin
      for (i = 0; i < 17; i++)
      begin
        rnd();
        if (k == 0)
          r = 8'hff;
        bus_op(1'b1, i, r);
        if (!(i inside {4, 6, 7, 8, 9, 16}))
        begin
          sh[i] = r;
          ex = {24'h0, r & ((i == 3) ? 8'h7f : 8'hff)};
          if (i < 2)
            check("decode", {24'h0, obs(i)}, ex);
          else if (i < 4)
            check("decode", {24'h0, obs(i)}, ex);
          else if (i < 10)
            check("decode", {24'h0, obs(i)}, ex);
          else if (i < 14)
            check("decode", {24'h0, obs(i)}, ex);
          else
            check("decode", {24'h0, obs(i)}, ex);
        end
      end
      for (i = 0; i < 17; i++)
      begin
        bus_op(1'b0, i, 8'h00);
        check("read back", rd, exp_rd(i));
      end
    end
    for (k = 0; k < 4; k++)
    begin
      rnd();
      r2 = r;
      rnd();
      @(posedge hclk);
      scan_line <= {r[0], r2};
      beam_h <= r;
      pen_strobe <= 1'b1;
      paddle_x_in <= r2;
      paddle_y_in <= ~r;
      paddle_load <= 1'b1;
      sh[6] = r;
      sh[7] = {r[0], r2[7:1]};
      sh[8] = r2;
      sh[9] = ~r;
      @(posedge hclk);
      pen_strobe <= 1'b0;
      paddle_load <= 1'b0;
      beam_h <= ~r;
      paddle_x_in <= ~r2;
      paddle_y_in <= r;
      scan_line <= {~r[0], r};
      for (i = 3; i < 10; i++)
      begin
        bus_op(1'b0, i, 8'h00);
        check("status read", rd, exp_rd(i));
      end
    end
    for (k = 0; k < 8; k++)
    begin
      rnd();
      sh[2] = {k[0], r[6:0]};
      bus_op(1'b1, 2, sh[2]);
      rnd();
      sh[15] = r;
      bus_op(1'b1, 15, r);
      rnd();
      sh[14] = r;
      bus_op(1'b1, 14, r);
      for (n = 0; n < 24; n++)
      begin
        rnd();
        r2 = (n == 0) ? 8'h1b : r;
        rnd();
        @(posedge hclk);
        cell_bits <= r2;
        colour_ptr <= r[3:0];
        dot_pos <= r[6:4];
        in_matrix <= r[7] | r2[0];
        @(posedge hclk);
        @(negedge hclk);
        ex = {28'h0, dot_exp(r2, r[3:0], r[6:4], r[7] | r2[0])};
        if (r[3])
          check("dot colour", {28'h0, dot_colour}, ex);
        else
          check("dot colour", {28'h0, dot_colour}, ex);
      end
    end
    give_verdict();
  end
  // ==========================================================
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge hclk);
    bad_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
